// [src/scg_core.sv]
// Start, repeated-start and stop condition generator for a two-wire bus.
// Assumes the shifter supplies bus state flags on the link clock.
`timescale 1ns/1ps
`default_nettype none
module scg_core
  import scg_pkg::*;
(
  // System
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic link_clk_i,
  // Register port
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  // Flags from the shifter, link clock domain
  input wire logic master_state_flag_i,
  input wire logic bus_busy_flag_i,
  input wire logic wait_ninth_i,
  input wire logic ninth_fall_i,
  input wire logic arb_lost_i,
  input wire logic stop_seen_i,
  // Bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic scl_oe_o,
  output logic sda_o,
  output logic sda_oe_o,
  // Status
  output logic start_done_o,
  output logic stop_done_o
);
  ////////////////////////////////////////////////////////////////////////
  // Link-side edge capture: pulses become toggles, levels are synced
  logic fall_tgl_q;
  logic fall_tgl_d;
  logic stop_tgl_q;
  logic stop_tgl_d;
  logic arb_tgl_q;
  logic arb_tgl_d;

  always_comb
  begin
    fall_tgl_d = fall_tgl_q ^ ninth_fall_i;
    stop_tgl_d = stop_tgl_q ^ stop_seen_i;
    arb_tgl_d = arb_tgl_q ^ arb_lost_i;
  end

  always_ff @(posedge link_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      fall_tgl_q <= 1'b0;
      stop_tgl_q <= 1'b0;
      arb_tgl_q <= 1'b0;
    end
    else
    begin
      fall_tgl_q <= fall_tgl_d;
      stop_tgl_q <= stop_tgl_d;
      arb_tgl_q <= arb_tgl_d;
    end
  end

  logic [7:0] sync_s;
  scg_link_sync #(.WIDTH(8)) u_sync (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .async_i({scl_i, sda_i, fall_tgl_q, stop_tgl_q, arb_tgl_q,
              master_state_flag_i, bus_busy_flag_i, wait_ninth_i}),
    .sync_o(sync_s)
  );

  logic scl_s;
  logic sda_s;
  logic master_s;
  logic busy_s;
  logic wait_s;
  logic [2:0] tgl_prev_q;
  logic [2:0] tgl_prev_d;
  logic fall_ev;
  logic stop_ev;
  logic arb_ev;
  logic wait_prev_q;
  logic wait_exit;

  assign scl_s = sync_s[7];
  assign sda_s = sync_s[6];
  assign master_s = sync_s[2];
  assign busy_s = sync_s[1];
  assign wait_s = sync_s[0];
  assign tgl_prev_d = sync_s[5:3];
  assign fall_ev = sync_s[5] ^ tgl_prev_q[2];
  assign stop_ev = sync_s[4] ^ tgl_prev_q[1];
  assign arb_ev = sync_s[3] ^ tgl_prev_q[0];
  assign wait_exit = wait_prev_q & ~wait_s;

  ////////////////////////////////////////////////////////////////////////
  // Registers
  logic [15:0] ctl_q;
  logic [15:0] ctl_d;
  logic start_fail_q;
  logic start_fail_d;
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;
  logic trg_start;
  logic trg_stop;
  logic trg_leave;
  logic ctl_wr;
  logic abort;
  logic enable;

  assign trg_start = wr_i && addr_i == ADDR_TRIGGER
    && wdata_i[TRG_START_BIT];
  assign trg_stop = wr_i && addr_i == ADDR_TRIGGER
    && wdata_i[TRG_STOP_BIT];
  assign trg_leave = wr_i && addr_i == ADDR_TRIGGER
    && wdata_i[TRG_LEAVE_BIT];
  assign ctl_wr = wr_i && addr_i == ADDR_CONTROL;
  assign enable = ctl_q[CTL_ENABLE_BIT];
  // Common abort terms for pending start and stop
  assign abort = (ctl_wr && !wdata_i[CTL_ENABLE_BIT]) || trg_leave
    || arb_ev;

  ////////////////////////////////////////////////////////////////////////
  // Condition sequencer
  scg_state_type st_q;
  scg_state_type st_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [CNT_W-1:0] buf_q;
  logic [CNT_W-1:0] buf_d;
  logic scl_rel_q;
  logic scl_rel_d;
  logic sda_rel_q;
  logic sda_rel_d;
  logic start_done_q;
  logic start_done_d;
  logic stop_done_q;
  logic stop_done_d;
  logic cnt_end;

  assign cnt_end = cnt_q == '0;

  always_comb
  begin
    st_d = st_q;
    cnt_d = cnt_end ? cnt_q : cnt_q - 1'b1;
    buf_d = (buf_q == '0) ? buf_q : buf_q - 1'b1;
    scl_rel_d = scl_rel_q;
    sda_rel_d = sda_rel_q;
    start_done_d = 1'b0;
    stop_done_d = 1'b0;
    start_fail_d = start_fail_q;
    ctl_d = ctl_wr ? wdata_i : ctl_q;
    // Bus-free timer restarts on any stop seen
    if (stop_ev)
      buf_d = CNT_W'(T_BUF_CYC);
    unique case (st_q)
      ST_IDLE:
      begin
        if (trg_start && enable && !abort)
        begin
          if (master_s)
            st_d = ST_WAIT_NINTH;
          else if (!busy_s || ctl_q[CTL_INIT_START_BIT])
          begin
            st_d = ST_BUF_WAIT;
          end
          else
            start_fail_d = 1'b1;
        end
        else if (trg_stop && enable && !abort)
        begin
          st_d = ST_SP_LOW;
          sda_rel_d = 1'b0;
          cnt_d = CNT_W'(T_LOW_CYC);
        end
      end
      ST_WAIT_NINTH:
      begin
        if (wait_exit || (fall_ev && !wait_s))
        begin
          st_d = ST_RS_LOW;
          cnt_d = CNT_W'(T_LOW_CYC);
        end
      end
      ST_RS_LOW:
      begin
        if (cnt_end)
        begin
          scl_rel_d = 1'b1;
          sda_rel_d = 1'b1;
          st_d = ST_RS_SETUP;
          cnt_d = CNT_W'(T_SU_STA_CYC);
        end
      end
      ST_RS_SETUP:
      begin
        if (cnt_end && scl_s)
        begin
          sda_rel_d = 1'b0;
          st_d = ST_START_HOLD;
          cnt_d = CNT_W'(T_HD_STA_CYC);
        end
      end
      ST_BUF_WAIT:
      begin
        if (buf_q == '0 || ctl_q[CTL_INIT_START_BIT])
        begin
          sda_rel_d = 1'b0;
          st_d = ST_START_HOLD;
          cnt_d = CNT_W'(T_HD_STA_CYC);
        end
      end
      ST_START_HOLD:
      begin
        if (cnt_end)
        begin
          scl_rel_d = 1'b0;
          start_done_d = 1'b1;
          st_d = ST_IDLE;
        end
      end
      ST_SP_LOW:
      begin
        if (cnt_end)
        begin
          scl_rel_d = 1'b1;
          st_d = ST_SP_WAIT_HIGH;
        end
      end
      ST_SP_WAIT_HIGH:
      begin
        if (scl_s && !sda_s)
        begin
          st_d = ST_SP_SETUP;
          cnt_d = CNT_W'(T_SU_STO_CYC);
        end
      end
      ST_SP_SETUP:
      begin
        if (cnt_end)
        begin
          sda_rel_d = 1'b1;
          stop_done_d = 1'b1;
          st_d = ST_IDLE;
        end
      end
      default:
        st_d = ST_IDLE;
    endcase
    // Aborts release the bus and drop any pending condition
    if (st_q != ST_IDLE && (abort || (stop_ev && st_q >= ST_SP_LOW)))
    begin
      st_d = ST_IDLE;
      scl_rel_d = 1'b1;
      sda_rel_d = 1'b1;
    end
    // Failed flag write-one-to-clear; set wins
    if (wr_i && addr_i == ADDR_STATUS && wdata_i[STS_START_FAILED_BIT]
        && start_fail_d == start_fail_q)
      start_fail_d = 1'b0;
    rdata_d = 16'h0000;
    if (rd_i)
    begin
      unique case (addr_i)
        ADDR_CONTROL: rdata_d = ctl_q;
        ADDR_STATUS:
        begin
          rdata_d[STS_MASTER_BIT] = master_s;
          rdata_d[STS_BUS_BUSY_BIT] = busy_s;
          rdata_d[STS_START_FAILED_BIT] = start_fail_q;
        end
        default: rdata_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      st_q <= ST_IDLE;
      cnt_q <= '0;
      buf_q <= '0;
      scl_rel_q <= 1'b1;
      sda_rel_q <= 1'b1;
      start_done_q <= 1'b0;
      stop_done_q <= 1'b0;
      start_fail_q <= 1'b0;
      ctl_q <= CONTROL_RESET;
      rdata_q <= 16'h0000;
      tgl_prev_q <= 3'b000;
      wait_prev_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      buf_q <= buf_d;
      scl_rel_q <= scl_rel_d;
      sda_rel_q <= sda_rel_d;
      start_done_q <= start_done_d;
      stop_done_q <= stop_done_d;
      start_fail_q <= start_fail_d;
      ctl_q <= ctl_d;
      rdata_q <= rdata_d;
      tgl_prev_q <= tgl_prev_d;
      wait_prev_q <= wait_s;
    end
  end

  // Open-drain: drive low only, release otherwise
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe_o = ~scl_rel_q;
  assign sda_oe_o = ~sda_rel_q;
  assign rdata_o = rdata_q;
  assign start_done_o = start_done_q;
  assign stop_done_o = stop_done_q;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb_chk @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  sequence s_hold_then_low;
    (st_q == ST_START_HOLD && cnt_end) ##1 !scl_rel_q;
  endsequence

  chk_busy_refuse: assert property (
    st_q == ST_IDLE && trg_start && enable && !abort && !master_s && busy_s
    && !ctl_q[CTL_INIT_START_BIT] |=> start_fail_q && st_q == ST_IDLE)
    else $error("busy start not refused");
  chk_hold_scl: assert property (
    st_q == ST_START_HOLD && !cnt_end && !abort |=> scl_rel_q)
    else $error("scl pulled before hold time");
  chk_hold_end: assert property (
    st_q == ST_START_HOLD && cnt_end && !abort |-> s_hold_then_low)
    else $error("scl not pulled after hold");
  chk_abort_drop: assert property (
    st_q != ST_IDLE && abort |=> st_q == ST_IDLE && sda_rel_q)
    else $error("abort did not drop condition");
  // Only a finished setup count makes a stop; an abort may also raise SDA
  chk_stop_sda: assert property (
    $rose(sda_rel_q) && st_q == ST_IDLE && $past(st_q) == ST_SP_SETUP
    && $past(cnt_end) |-> stop_done_q)
    else $error("stop edge without done");
  chk_buf_wait: assert property (
    st_q == ST_BUF_WAIT && buf_q != '0 && !ctl_q[CTL_INIT_START_BIT]
    && !abort |=> sda_rel_q)
    else $error("start before bus free time");
  chk_ninth_wait: assert property (
    st_q == ST_WAIT_NINTH && !wait_exit && !fall_ev && !abort
    |=> st_q == ST_WAIT_NINTH)
    else $error("restart began early");
  chk_restart_low: assert property (
    st_q == ST_RS_LOW && !abort |=> !sda_rel_q || st_q != ST_RS_LOW)
    else $error("restart released early");
  chk_stop_drop: assert property (
    st_q >= ST_SP_LOW && stop_ev
    |=> st_q == ST_IDLE && scl_rel_q && sda_rel_q)
    else $error("stop seen did not drop stop");
endmodule : scg_core
`default_nettype wire

// [src/scg_link_sync.sv]
// Two-flop synchroniser for link-side levels.
// Assumes inputs are asynchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none
module scg_link_sync #(
  parameter int WIDTH = 2
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Levels
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  always_comb
  begin
    meta_d = async_i;
    sync_d = meta_q;
  end

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_o = sync_q;
endmodule : scg_link_sync
`default_nettype wire

// [src/scg_pkg.sv]
// Package for the bus start/stop condition generator.
// Assumes a 200 MHz system clock and a separate link clock domain.
package scg_pkg;
  // Register map (word offsets shown as byte addresses)
  localparam logic [3:0] ADDR_TRIGGER = 4'h0;
  localparam logic [3:0] ADDR_CONTROL = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  // Trigger fields
  localparam int TRG_STOP_BIT = 0;
  localparam int TRG_START_BIT = 1;
  localparam int TRG_LEAVE_BIT = 3;
  // Control fields
  localparam int CTL_ENABLE_BIT = 0;
  localparam int CTL_INIT_START_BIT = 1;
  // Status fields
  localparam int STS_START_FAILED_BIT = 1;
  localparam int STS_ARB_LOST_BIT = 0;
  localparam int STS_BUS_BUSY_BIT = 6;
  localparam int STS_MASTER_BIT = 15;
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  // Timing, standard mode minima in ns
  localparam int CLK_PERIOD_NS = 5;
  localparam int T_LOW_NS = 4700;
  localparam int T_SU_STA_NS = 4700;
  localparam int T_HD_STA_NS = 4000;
  localparam int T_SU_STO_NS = 4000;
  localparam int T_BUF_NS = 4700;
  // Least times round up
  localparam int T_LOW_CYC = (T_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_SU_STA_CYC =
    (T_SU_STA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_HD_STA_CYC =
    (T_HD_STA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_SU_STO_CYC =
    (T_SU_STO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_BUF_CYC = (T_BUF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 12;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_WAIT_NINTH = 4'b0001,
    ST_RS_LOW = 4'b0010,
    ST_RS_SETUP = 4'b0011,
    ST_BUF_WAIT = 4'b0100,
    ST_START_HOLD = 4'b0101,
    ST_SP_LOW = 4'b0110,
    ST_SP_WAIT_HIGH = 4'b0111,
    ST_SP_SETUP = 4'b1000
  } scg_state_type;
endpackage : scg_pkg

// [test/scg_bus_model.sv]
// Bus partner: pull-ups, a slow slave, other masters and the shifter.
// Assumes the bench steers it with levels and toggles.
`timescale 1ns/1ps
`default_nettype none
module scg_bus_model (
  // Link clock
  input wire logic link_clk_i,
  // Steering from the bench
  input wire logic master_i,
  input wire logic busy_i,
  input wire logic wait_i,
  input wire logic slow_i,
  input wire logic [2:0] tgl_i,
  // Device pins
  input wire logic scl_oe_i,
  input wire logic sda_oe_i,
  output logic scl_o,
  output logic sda_o,
  // Flags, link domain
  output logic master_o,
  output logic busy_o,
  output logic wait_o,
  output logic [2:0] pulse_o
);
  logic [2:0] tgl_q = 3'h0;
  logic [4:0] hold_q = 5'h00;
  logic sda_prev_q = 1'b1;
  // Flags known before the first link edge, so no unknown reaches the block
  initial
  begin
    master_o = 1'b0;
    busy_o = 1'b0;
    wait_o = 1'b0;
    pulse_o = 3'h0;
  end
  // Open drain with pull-ups; a slow slave stretches SCL
  assign scl_o = !(scl_oe_i || hold_q != 5'h00);
  assign sda_o = !sda_oe_i;
  always @(posedge link_clk_i)
  begin
    // Flags follow the bench steering, registered on each link edge
    master_o <= master_i;
    busy_o <= busy_i;
    wait_o <= wait_i;
    // Stop seen when SDA rises while SCL is high
    pulse_o <= (tgl_q ^ tgl_i) | {2'b00, sda_o && !sda_prev_q && scl_o};
    sda_prev_q <= sda_o;
    tgl_q <= tgl_i;
    if (scl_oe_i)
      hold_q <= slow_i ? 5'h14 : 5'h00;
    else if (hold_q != 5'h00)
      hold_q <= hold_q - 5'h01;
  end
endmodule : scg_bus_model
`default_nettype wire

// [test/scg_core_tb.sv]
// Bench for the start and stop condition generator.
// Assumes the package and the bus partner are compiled first.
`timescale 1ns/1ps
`default_nettype none
module scg_core_tb
  import scg_pkg::*;
;
  logic clk_i = 1'b0;
  logic lclk = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic ms = 1'b0;
  logic busy = 1'b0;
  logic wt = 1'b0;
  logic slow = 1'b0;
  logic [2:0] tg = 3'h0;
  logic [15:0] rdata;
  logic [15:0] d;
  logic mf, bf, wf, scl, sda, scl_oe, sda_oe, so, dd, st, pd;
  logic [2:0] pl;
  int num_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  int t0 = 0;
  int t1 = 0;
  int n;
  always #2.5 clk_i = ~clk_i;
  always @(posedge clk_i) cyc <= cyc + 1;
  // Link clock offset so the two domains never line up
  initial
  begin
    #3;
    forever #16 lclk = ~lclk;
  end
  scg_core DUT (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .link_clk_i(lclk),
    .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .master_state_flag_i(mf), .bus_busy_flag_i(bf), .wait_ninth_i(wf),
    .ninth_fall_i(pl[2]), .arb_lost_i(pl[1]), .stop_seen_i(pl[0]),
    .scl_i(scl),
    .sda_i(sda), .scl_o(so), .scl_oe_o(scl_oe), .sda_o(dd),
    .sda_oe_o(sda_oe), .start_done_o(st), .stop_done_o(pd));
  scg_bus_model BUS (.link_clk_i(lclk), .master_i(ms), .busy_i(busy),
    .wait_i(wt), .slow_i(slow), .tgl_i(tg), .scl_oe_i(scl_oe),
    .sda_oe_i(sda_oe), .scl_o(scl), .sda_o(sda), .master_o(mf),
    .busy_o(bf), .wait_o(wf), .pulse_o(pl));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string s, input logic [15:0] e,
    input logic [15:0] g);
    n_tests++;
    if (g !== e)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic chk_n(input string s, input int lo, input int hi,
    input int g);
    n_tests++;
    if (g < lo || g > hi)
    begin
      num_errors++;
      $display("Error %s expected %0d..%0d seen %0d", s, lo, hi, g);
    end
  endtask : chk_n
  task automatic tick(input int c);
    repeat (c) @(posedge clk_i);
    #1;
  endtask : tick
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk_i);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, output logic [15:0] v);
    @(posedge clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask : rd_reg
  // Bounded so a stuck output ends as a count mismatch, not a hang
  task automatic wait_oe(input bit sel, input logic lv, output int c);
    c = 0;
    while ((sel ? sda_oe : scl_oe) !== lv && c < 5000)
    begin
      tick(1);
      c++;
    end
  endtask : wait_oe
  task automatic watch(input int c, input logic [1:0] e, output int h);
    h = 0;
    repeat (c)
    begin
      tick(1);
      h += ({scl_oe, sda_oe} !== e);
    end
  endtask : watch
  task automatic end_test(input string s);
    $display("Test %s finished, mismatches so far %0d", s, num_errors);
  endtask : end_test
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict
  task automatic start_tail(input int lo, input int hi);
    wait_oe(1, 1'b1, n);
    t1 = cyc;
    chk_n("start delay", lo, hi, n);
    chk("scl high at sda fall", 16'h0001, {15'h0, scl});
    wait_oe(0, 1'b1, n);
    chk_n("start hold", T_HD_STA_CYC, T_HD_STA_CYC + 2, n);
    chk("start done", 16'h0001, {15'h0, st});
  endtask : start_tail
  task automatic do_stop();
    ms <= 1'b1;
    wt <= 1'b1;
    slow <= 1'($urandom_range(1, 0));
    tick(40);
    wr_reg(ADDR_TRIGGER, 16'h0001);
    wt <= 1'b0;
    wait_oe(1, 1'b1, n);
    t1 = cyc;
    while (scl !== 1'b1 && cyc - t1 < 9000)
      tick(1);
    chk("sda held at scl rise", 16'h0001, {15'h0, sda_oe});
    wait_oe(1, 1'b0, n);
    chk_n("stop timing", T_LOW_CYC + T_SU_STO_CYC,
      T_LOW_CYC + T_SU_STO_CYC + 170, cyc - t1);
    chk("stop done", 16'h0001, {15'h0, pd});
    t0 = cyc;
    ms <= 1'b0;
    tick(40);
  endtask : do_stop
  task automatic restart(input bit via_fall);
    ms <= 1'b1;
    slow <= 1'b0;
    wt <= !via_fall;
    tick(40);
    wr_reg(ADDR_TRIGGER, 16'h0002);
    watch(150, 2'b11, n);
    chk_n("restart held", 0, 0, n);
    if (via_fall)
      tg[2] <= !tg[2];
    else
      wt <= 1'b0;
    wait_oe(1, 1'b0, n);
    chk_n("restart low", T_LOW_CYC, T_LOW_CYC + 40, n);
    chk("scl released", 16'h0000, {15'h0, scl_oe});
    start_tail(T_SU_STA_CYC, T_SU_STA_CYC + 30);
  endtask : restart
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(32'hb773));
    repeat (4) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rd_reg(ADDR_CONTROL, d);
    chk("control reset", CONTROL_RESET, d);
    rd_reg(ADDR_STATUS, d);
    chk("status reset", 16'h0000, d);
    rd_reg(4'hc, d);
    chk("unmapped", 16'h0000, d);
    chk("drive levels", 16'h0000, {14'h0, so, dd});
    wr_reg(ADDR_TRIGGER, 16'h0002);
    watch(300, 2'b00, n);
    chk_n("start while disabled", 0, 0, n);
    wr_reg(ADDR_CONTROL, 16'h0001);
    wr_reg(ADDR_TRIGGER, 16'($urandom) & 16'hfff4);
    watch(300, 2'b00, n);
    chk_n("trigger zero", 0, 0, n);
    end_test("registers");
    busy <= 1'b1;
    tick(40);
    wr_reg(ADDR_TRIGGER, 16'h0002);
    watch(1200, 2'b00, n);
    chk_n("busy start", 0, 0, n);
    rd_reg(ADDR_STATUS, d);
    chk("start failed", 16'h0001, {15'h0, d[STS_START_FAILED_BIT]});
    chk("busy seen", 16'h0001, {15'h0, d[STS_BUS_BUSY_BIT]});
    wr_reg(ADDR_STATUS, 16'h0002);
    rd_reg(ADDR_STATUS, d);
    chk("failed cleared", 16'h0000, {15'h0, d[STS_START_FAILED_BIT]});
    end_test("refusal");
    wr_reg(ADDR_CONTROL, 16'h0003);
    wr_reg(ADDR_TRIGGER, 16'h0002);
    start_tail(0, T_BUF_CYC + 8);
    do_stop();
    end_test("forced start");
    busy <= 1'b0;
    wr_reg(ADDR_CONTROL, 16'h0001);
    tick(1000);
    wr_reg(ADDR_TRIGGER, 16'h0002);
    start_tail(0, 8);
    rd_reg(ADDR_TRIGGER, d);
    chk("start trigger cleared", 16'h0000, d & 16'h0003);
    restart(1'b0);
    restart(1'b1);
    end_test("start and restart");
    // Abort kinds: disable, leave, arbitration loss, then none
    for (int k = 0; k < 4; k++)
    begin
      do_stop();
      wr_reg(ADDR_TRIGGER, 16'h0002);
      tick(50);
      if (k == 0)
        wr_reg(ADDR_CONTROL, 16'h0000);
      if (k == 1)
        wr_reg(ADDR_TRIGGER, 16'h0008);
      if (k == 2)
        tg[1] <= !tg[1];
      if (k < 3)
      begin
        watch(1200, 2'b00, n);
        chk_n("dropped start", 0, 0, n);
        wr_reg(ADDR_CONTROL, 16'h0001);
      end
    end
    start_tail(0, 5000);
    // The stop reaches the timer through two link edges and a synchroniser
    chk_n("bus free", T_BUF_CYC, T_BUF_CYC + 24, t1 - t0);
    wr_reg(ADDR_TRIGGER, 16'h0001);
    tick(100);
    tg[0] <= !tg[0];
    tick(30);
    watch(600, 2'b00, n);
    chk_n("dropped stop", 0, 0, n);
    end_test("aborts and bus free");
    print_verdict();
  end
  initial
  begin
    #400000;
    num_errors++;
    print_verdict();
  end
endmodule : scg_core_tb
`default_nettype wire
